// ==== shared/irq_map.vh ====
`ifndef IRQ_MAP_VH
`define IRQ_MAP_VH
// Register offsets (byte addresses)
`define OFS_SET_EN 12'h000
`define OFS_CLR_EN 12'h080
`define OFS_SET_PEND 12'h100
`define OFS_CLR_PEND 12'h180
`define OFS_ACTIVE 12'h200
`define OFS_PRIO 12'h300
`define OFS_TICK_CSR 12'h400
`define OFS_TICK_RELOAD 12'h404
`define OFS_TICK_CUR 12'h408
`define OFS_TICK_CALIB 12'h40c
`define OFS_PINMUX 12'h500
`define OFS_STACKED 12'h504
// Field positions
`define TICK_EN_BIT 0
`define TICK_INT_BIT 1
`define TICK_CLKSRC_BIT 2
`define TICK_FLAG_BIT 16
`define CALIB_TICK_NO_REFERENCE_FLAG_BIT 31
`define PINMUX_NMI_BIT 0
// Geometry
`define NUM_IRQ 74
`define PRIO_W 4
`define PRIO_IDLE 5'h10
`define VEC_OFS 16
`define BANK_BITS 32
`define PRIO_PER_REG 4
`define TICK_W 24
// Request line numbers
`define IRQ_DMA_ERR 16
`define IRQ_LOW_LEAK_WAKEUP_UNIT 21
`define IRQ_SOFTWARE_WATCHDOG 22
`define IRQ_SPI0 26
`define IRQ_UART0_ST 31
`define IRQ_FTM0 42
`define IRQ_SOFT 64
// Reset values and answers
`define PINMUX_RST 1'b0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== core/irq_source_router.v ====
`timescale 1ns/1ps
`include "irq_map.vh"
module irq_source_router #(
  parameter N = `NUM_IRQ,
  parameter SPI_CAUSES = 4,
  parameter FTM_CAUSES = 8
) (
  // Sources
  input wire [3:0] dma_done,
  input wire [3:0] dma_err,
  input wire [3:0] misc_irq,
  input wire low_leak_wakeup_unit_irq,
  input wire software_watchdog_irq,
  input wire ewm_irq,
  input wire i2c0_irq,
  input wire [SPI_CAUSES-1:0] spi0_causes,
  input wire [1:0] uart_stat,
  input wire [1:0] uart_err,
  input wire [3:0] analog_irq,
  input wire [3*FTM_CAUSES-1:0] ftm_causes,
  input wire [3:0] pit_irq,
  input wire [3:0] misc2_irq,
  input wire [4:0] port_irq,
  input wire adc1_irq,
  // Request lines
  output reg [N-1:0] req
);
  // Unlisted lines and the software line stay zero
  always @* begin
    req = {N{1'b0}};
    req[3:0] = dma_done;
    req[`IRQ_DMA_ERR] = |dma_err;
    req[20:17] = misc_irq;
    req[`IRQ_LOW_LEAK_WAKEUP_UNIT] = low_leak_wakeup_unit_irq;
    req[`IRQ_SOFTWARE_WATCHDOG] = software_watchdog_irq | ewm_irq;
    req[24] = i2c0_irq;
    req[`IRQ_SPI0] = |spi0_causes;
    req[`IRQ_UART0_ST] = uart_stat[0];
    req[32] = uart_err[0];
    req[33] = uart_stat[1];
    req[34] = uart_err[1];
    req[39] = analog_irq[0];
    req[41:40] = analog_irq[2:1];
    req[72] = analog_irq[3];
    req[`IRQ_FTM0] = |ftm_causes[FTM_CAUSES-1:0];
    req[43] = |ftm_causes[2*FTM_CAUSES-1:FTM_CAUSES];
    req[44] = |ftm_causes[3*FTM_CAUSES-1:2*FTM_CAUSES];
    req[51:48] = pit_irq;
    req[52] = misc2_irq[0];
    req[58:56] = misc2_irq[3:1];
    req[63:59] = port_irq;
    req[73] = adc1_irq;
  end
endmodule // irq_source_router

// ==== core/system_tick_timer.v ====
`timescale 1ns/1ps
`include "irq_map.vh"
module system_tick_timer #(
  parameter W = `TICK_W
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire enable,
  input wire [W-1:0] reload,
  input wire cur_clr,
  input wire flag_clr,
  // Status
  output reg [W-1:0] current_r,
  output reg countflag_r,
  output reg wrap_r
);
  // Down counter on every core clock edge, reload at zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      current_r <= {W{1'b0}};
      countflag_r <= 1'b0;
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= enable && (current_r == {{(W-1){1'b0}}, 1'b1});
      if (cur_clr) begin
        current_r <= {W{1'b0}};
      end else if (enable) begin
        if (current_r == {W{1'b0}}) begin
          current_r <= reload;
        end else begin
          current_r <= current_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
      // Set wins over read clear
      if (enable && !cur_clr && current_r == {{(W-1){1'b0}}, 1'b1}) begin
        countflag_r <= 1'b1;
      end else if (flag_clr || cur_clr) begin
        countflag_r <= 1'b0;
      end
    end
  end
endmodule // system_tick_timer

// ==== core/core_interrupt_integration.v ====
`timescale 1ns/1ps
`include "irq_map.vh"
module core_interrupt_integration #(
  parameter N = `NUM_IRQ,
  parameter SPI_CAUSES = 4,
  parameter FTM_CAUSES = 8,
  parameter AW = 32
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [11:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [11:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Peripheral sources
  input wire [3:0] dma_done,
  input wire [3:0] dma_err,
  input wire [3:0] misc_irq,
  input wire low_leak_wakeup_unit_irq,
  input wire software_watchdog_irq,
  input wire ewm_irq,
  input wire i2c0_irq,
  input wire [SPI_CAUSES-1:0] spi0_causes,
  input wire [1:0] uart_stat,
  input wire [1:0] uart_err,
  input wire [3:0] analog_irq,
  input wire [3*FTM_CAUSES-1:0] ftm_causes,
  input wire [3:0] pit_irq,
  input wire [3:0] misc2_irq,
  input wire [4:0] port_irq,
  input wire adc1_irq,
  // Non-maskable pin
  input wire nmi_pin_n,
  // Core exception interface
  output reg irq_valid_r,
  output reg [7:0] irq_vector_r,
  output reg [3:0] irq_level_r,
  input wire irq_ack,
  input wire irq_exit,
  output reg [7:0] stacked_vector_r,
  output reg nmi_req_r,
  output reg tick_req_r,
  // Core buses
  input wire ifetch_valid,
  input wire [AW-1:0] ifetch_addr,
  input wire data_code_bus_valid,
  input wire [AW-1:0] data_code_bus_addr,
  input wire sysbus_valid,
  input wire [AW-1:0] sysbus_addr,
  output reg code_port_valid_r,
  output reg [AW-1:0] code_port_addr_r,
  output reg code_port_is_data_r,
  output reg sys_port_valid_r,
  output reg [AW-1:0] sys_port_addr_r
);
  localparam NB = (N + `BANK_BITS - 1) / `BANK_BITS; // Bank registers
  localparam NP = (N + `PRIO_PER_REG - 1) / `PRIO_PER_REG; // Priority registers

  // Bank index of a request
  function integer bank_of(input integer i);
    bank_of = i / `BANK_BITS;
  endfunction
  // Bit within a bank register
  function integer bit_of(input integer i);
    bit_of = i % `BANK_BITS;
  endfunction
  // Priority register index
  function integer preg_of(input integer i);
    preg_of = i / `PRIO_PER_REG;
  endfunction
  // Lowest bit of priority field
  function integer plsb_of(input integer i);
    plsb_of = 8 * (i % `PRIO_PER_REG) + `PRIO_W;
  endfunction

  wire [N-1:0] req; // Routed request lines
  reg [N-1:0] en_r; // Enable bits
  reg [N-1:0] pend_r; // Pending bits
  reg [N-1:0] act_r; // Active bits
  reg [`PRIO_W-1:0] prio_r [0:N-1]; // Priority fields
  reg tick_en_r; // Tick enable
  reg tick_int_r; // Tick exception enable
  reg [`TICK_W-1:0] tick_reload_r; // Tick reload
  reg nmi_sel_r; // Pin mux selects NMI
  wire [`TICK_W-1:0] tick_cur; // Tick count
  wire tick_flag; // Tick count flag
  wire tick_wrap; // Tick reached zero
  wire wr_go; // Write handshake
  wire rd_go; // Read handshake
  wire [9:0] wr_idx; // Write word index
  wire [9:0] rd_idx; // Read word index
  reg wr_hit; // Write address mapped
  reg [31:0] rd_word; // Read mux
  reg rd_hit; // Read address mapped
  reg cand_found; // Candidate exists
  reg [6:0] cand_idx; // Candidate request
  reg [4:0] cand_prio; // Candidate level
  reg [4:0] run_prio; // Running level
  wire [6:0] ack_idx; // Request being taken
  integer i;

  assign wr_go = awvalid && wvalid && awready;
  assign rd_go = arvalid && arready;
  assign wr_idx = awaddr[11:2];
  assign rd_idx = araddr[11:2];
  assign ack_idx = irq_vector_r[6:0] - 7'd`VEC_OFS;

  // Route peripheral lines
  irq_source_router #(.N(N), .SPI_CAUSES(SPI_CAUSES), .FTM_CAUSES(FTM_CAUSES)) u_router (
    .dma_done(dma_done), .dma_err(dma_err), .misc_irq(misc_irq), .low_leak_wakeup_unit_irq(low_leak_wakeup_unit_irq),
    .software_watchdog_irq(software_watchdog_irq), .ewm_irq(ewm_irq), .i2c0_irq(i2c0_irq), .spi0_causes(spi0_causes),
    .uart_stat(uart_stat), .uart_err(uart_err), .analog_irq(analog_irq), .ftm_causes(ftm_causes),
    .pit_irq(pit_irq), .misc2_irq(misc2_irq), .port_irq(port_irq), .adc1_irq(adc1_irq),
    .req(req)
  );

  // Tick timer, write to current clears it
  system_tick_timer #(.W(`TICK_W)) u_tick (
    .aclk(aclk), .aresetn(aresetn), .enable(tick_en_r), .reload(tick_reload_r),
    .cur_clr(wr_go && wr_hit && {wr_idx, 2'b00} == `OFS_TICK_CUR),
    .flag_clr(rd_go && {rd_idx, 2'b00} == `OFS_TICK_CSR),
    .current_r(tick_cur), .countflag_r(tick_flag), .wrap_r(tick_wrap)
  );

  // Address decode for writes
  always @* begin
    wr_hit = 1'b0;
    if (awaddr[11:7] <= `OFS_ACTIVE >> 7 && awaddr[6:2] < NB) begin
      wr_hit = 1'b1;
    end else if (awaddr[11:8] == `OFS_PRIO >> 8 && awaddr[7:2] < NP) begin
      wr_hit = 1'b1;
    end else if ({wr_idx, 2'b00} >= `OFS_TICK_CSR && {wr_idx, 2'b00} <= `OFS_TICK_CALIB) begin
      wr_hit = 1'b1;
    end else if ({wr_idx, 2'b00} == `OFS_PINMUX || {wr_idx, 2'b00} == `OFS_STACKED) begin
      wr_hit = 1'b1;
    end
  end

  // Read mux
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (araddr[11:7] <= `OFS_ACTIVE >> 7 && araddr[6:2] < NB) begin
      for (i = 0; i < N; i = i + 1) begin
        if (bank_of(i) == araddr[6:2]) begin
          case (araddr[9:7])
            3'h0, 3'h1: rd_word[bit_of(i)] = en_r[i];
            3'h2, 3'h3: rd_word[bit_of(i)] = pend_r[i];
            default: rd_word[bit_of(i)] = act_r[i];
          endcase
        end
      end
    end else if (araddr[11:8] == `OFS_PRIO >> 8 && araddr[7:2] < NP) begin
      for (i = 0; i < N; i = i + 1) begin
        if (preg_of(i) == araddr[7:2]) begin
          rd_word[plsb_of(i) +: `PRIO_W] = prio_r[i];
        end
      end
    end else begin
      case ({rd_idx, 2'b00})
        `OFS_TICK_CSR: begin
          rd_word[`TICK_EN_BIT] = tick_en_r;
          rd_word[`TICK_INT_BIT] = tick_int_r;
          rd_word[`TICK_CLKSRC_BIT] = 1'b1;
          rd_word[`TICK_FLAG_BIT] = tick_flag;
        end
        `OFS_TICK_RELOAD: rd_word[`TICK_W-1:0] = tick_reload_r;
        `OFS_TICK_CUR: rd_word[`TICK_W-1:0] = tick_cur;
        // Ten-ms field zero, no-reference flag set
        `OFS_TICK_CALIB: rd_word[`CALIB_TICK_NO_REFERENCE_FLAG_BIT] = 1'b1;
        `OFS_PINMUX: rd_word[`PINMUX_NMI_BIT] = nmi_sel_r;
        `OFS_STACKED: rd_word[7:0] = stacked_vector_r;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Pick highest enabled pending request; lowest number wins ties
  always @* begin
    cand_found = 1'b0;
    cand_idx = 7'h00;
    cand_prio = `PRIO_IDLE;
    run_prio = `PRIO_IDLE;
    for (i = 0; i < N; i = i + 1) begin
      if (act_r[i] && {1'b0, prio_r[i]} < run_prio) begin
        run_prio = {1'b0, prio_r[i]};
      end
    end
    for (i = 0; i < N; i = i + 1) begin
      if (pend_r[i] && en_r[i] && !act_r[i] && {1'b0, prio_r[i]} < cand_prio) begin
        cand_found = 1'b1;
        cand_idx = i[6:0];
        cand_prio = {1'b0, prio_r[i]};
      end
    end
    if (cand_prio >= run_prio) begin
      cand_found = 1'b0;
    end
  end

  // AXI4-Lite handshakes and answers
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      // Take address and data together, one cycle after both offered
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      arready <= arvalid && !arready && !rvalid;
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Register writes and interrupt state
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= {N{1'b0}};
      pend_r <= {N{1'b0}};
      act_r <= {N{1'b0}};
      for (i = 0; i < N; i = i + 1) begin
        prio_r[i] <= {`PRIO_W{1'b0}};
      end
      tick_en_r <= 1'b0;
      tick_int_r <= 1'b0;
      tick_reload_r <= {`TICK_W{1'b0}};
      nmi_sel_r <= `PINMUX_RST;
      stacked_vector_r <= 8'h00;
    end else begin
      for (i = 0; i < N; i = i + 1) begin
        // Bank writes reach bit irq mod 32 of register irq div 32
        if (wr_go && awaddr[11:10] == 2'b00 && awaddr[6:2] == bank_of(i) && wdata[bit_of(i)]) begin
          case (awaddr[9:7])
            3'h0: en_r[i] <= 1'b1;
            3'h1: en_r[i] <= 1'b0;
            default: ;
          endcase
        end
        // Hardware set, software set and ack; set wins over clear
        if (req[i] || (wr_go && awaddr[11:7] == `OFS_SET_PEND >> 7 && awaddr[6:2] == bank_of(i)
            && wdata[bit_of(i)])) begin
          pend_r[i] <= 1'b1;
        end else if ((wr_go && awaddr[11:7] == `OFS_CLR_PEND >> 7 && awaddr[6:2] == bank_of(i)
            && wdata[bit_of(i)]) || (irq_ack && irq_valid_r && ack_idx == i)) begin
          pend_r[i] <= 1'b0;
        end
        // Active set on ack, cleared on return
        if (irq_ack && irq_valid_r && ack_idx == i) begin
          act_r[i] <= 1'b1;
        end else if (irq_exit && stacked_vector_r[6:0] == i + `VEC_OFS) begin
          act_r[i] <= 1'b0;
        end
        // Priority bytes honour strobes
        if (wr_go && awaddr[11:8] == `OFS_PRIO >> 8 && awaddr[7:2] == preg_of(i)
            && wstrb[i % `PRIO_PER_REG]) begin
          prio_r[i] <= wdata[plsb_of(i) +: `PRIO_W];
        end
      end
      if (wr_go && {wr_idx, 2'b00} == `OFS_TICK_CSR && wstrb[0]) begin
        tick_en_r <= wdata[`TICK_EN_BIT];
        tick_int_r <= wdata[`TICK_INT_BIT];
      end
      if (wr_go && {wr_idx, 2'b00} == `OFS_TICK_RELOAD) begin
        tick_reload_r <= wdata[`TICK_W-1:0];
      end
      if (wr_go && {wr_idx, 2'b00} == `OFS_PINMUX && wstrb[0]) begin
        nmi_sel_r <= wdata[`PINMUX_NMI_BIT];
      end
      // Vector of the serviced interrupt kept for the stack frame
      if (irq_ack && irq_valid_r) begin
        stacked_vector_r <= irq_vector_r;
      end
    end
  end

  // Presentation to the core
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_valid_r <= 1'b0;
      irq_vector_r <= 8'h00;
      irq_level_r <= 4'h0;
      nmi_req_r <= 1'b0;
      tick_req_r <= 1'b0;
    end else begin
      irq_valid_r <= cand_found && !(irq_ack && irq_valid_r);
      irq_vector_r <= {1'b0, cand_idx} + 8'd`VEC_OFS;
      irq_level_r <= cand_prio[3:0];
      nmi_req_r <= nmi_sel_r && !nmi_pin_n;
      if (tick_wrap && tick_int_r) begin
        tick_req_r <= 1'b1;
      end else if (irq_ack && !irq_valid_r) begin
        tick_req_r <= 1'b0;
      end
    end
  end

  // Code bus mux and system bus port
  always @(posedge aclk) begin
    if (!aresetn) begin
      code_port_valid_r <= 1'b0;
      code_port_addr_r <= {AW{1'b0}};
      code_port_is_data_r <= 1'b0;
      sys_port_valid_r <= 1'b0;
      sys_port_addr_r <= {AW{1'b0}};
    end else begin
      // Data-code access takes the shared port first
      code_port_valid_r <= ifetch_valid || data_code_bus_valid;
      code_port_is_data_r <= data_code_bus_valid;
      code_port_addr_r <= data_code_bus_valid ? data_code_bus_addr : ifetch_addr;
      sys_port_valid_r <= sysbus_valid;
      sys_port_addr_r <= sysbus_addr;
    end
  end
endmodule // core_interrupt_integration

// ==== verification/irq_checker_props.sv ====
`timescale 1ns/1ps
`include "irq_map.vh"
module irq_checker #(
  parameter N = 74,
  parameter AW = 32
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Read channel
  input logic [11:0] araddr,
  input logic arvalid,
  input logic arready,
  input logic rvalid,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  // Exception side
  input logic nmi_pin_n,
  input logic nmi_req_r,
  input logic irq_valid_r,
  input logic [7:0] irq_vector_r,
  input logic irq_ack,
  input logic [7:0] stacked_vector_r,
  // Core buses
  input logic ifetch_valid,
  input logic [AW-1:0] ifetch_addr,
  input logic data_code_bus_valid,
  input logic [AW-1:0] data_code_bus_addr,
  input logic sysbus_valid,
  input logic [AW-1:0] sysbus_addr,
  input logic code_port_valid_r,
  input logic [AW-1:0] code_port_addr_r,
  input logic code_port_is_data_r,
  input logic sys_port_valid_r,
  input logic [AW-1:0] sys_port_addr_r
);
  logic [11:0] rd_addr_r; // Address of the read under way
  // Remember the accepted read address until the data returns
  always @(posedge aclk) begin
    if (!aresetn) rd_addr_r <= 12'h000;
    else if (arvalid && arready) rd_addr_r <= araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_nmi_from_pin: assert property (nmi_req_r |-> !$past(nmi_pin_n))
    else $error("nmi request without low pin");
  a_vector_range: assert property (irq_valid_r |-> irq_vector_r >= 8'h10 && irq_vector_r < (16 + N))
    else $error("vector outside peripheral range");
  a_stack_load: assert property (irq_ack && irq_valid_r |=> stacked_vector_r == $past(irq_vector_r))
    else $error("stacked vector not recorded");
  a_code_data_wins: assert property (data_code_bus_valid |=> code_port_valid_r && code_port_is_data_r
    && code_port_addr_r == $past(data_code_bus_addr))
    else $error("data-code access not forwarded");
  a_code_fetch: assert property (ifetch_valid && !data_code_bus_valid |=> code_port_valid_r && !code_port_is_data_r
    && code_port_addr_r == $past(ifetch_addr))
    else $error("fetch access not forwarded");
  a_sys_port: assert property (sysbus_valid |=> sys_port_valid_r && sys_port_addr_r == $past(sysbus_addr))
    else $error("system bus access not forwarded");
  a_tick_source: assert property (rvalid && rd_addr_r == `OFS_TICK_CSR |-> rdata[2])
    else $error("tick source bit clear");
  a_calib_fixed: assert property (rvalid && rd_addr_r == `OFS_TICK_CALIB |-> rdata == 32'h8000_0000)
    else $error("calibration word wrong");
  a_prio_nibble: assert property (rvalid && rd_addr_r >= `OFS_PRIO && rd_addr_r < 12'h34c
    |-> (rdata & 32'h0f0f_0f0f) == 32'h0)
    else $error("priority low nibble not zero");
  // Main scenarios
  c_ack: cover property (irq_ack && irq_valid_r);
  c_nmi: cover property (nmi_req_r);
  c_slverr: cover property (rvalid && rresp == `RESP_SLVERR);
endmodule // irq_checker

bind core_interrupt_integration irq_checker #(.N(N), .AW(AW)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .nmi_pin_n(nmi_pin_n), .nmi_req_r(nmi_req_r),
  .irq_valid_r(irq_valid_r), .irq_vector_r(irq_vector_r), .irq_ack(irq_ack),
  .stacked_vector_r(stacked_vector_r), .ifetch_valid(ifetch_valid), .ifetch_addr(ifetch_addr),
  .data_code_bus_valid(data_code_bus_valid), .data_code_bus_addr(data_code_bus_addr), .sysbus_valid(sysbus_valid),
  .sysbus_addr(sysbus_addr), .code_port_valid_r(code_port_valid_r), .code_port_addr_r(code_port_addr_r),
  .code_port_is_data_r(code_port_is_data_r), .sys_port_valid_r(sys_port_valid_r),
  .sys_port_addr_r(sys_port_addr_r));

// ==== verification/core_model.sv ====
`timescale 1ns/1ps
module core_model #(
  parameter ACK_AT = 3
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Candidate from the interrupt unit
  input logic irq_valid_r,
  input logic [7:0] irq_vector_r,
  // Answers of the core
  output logic irq_ack,
  output logic irq_exit,
  output logic [7:0] taken_vec_r
);
  logic [3:0] cnt_r; // Steps of one entry and return
  // Take a candidate after a delay, return from it later
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
      irq_ack <= 1'b0;
      irq_exit <= 1'b0;
      taken_vec_r <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      irq_exit <= 1'b0;
      // Idle until a candidate shows
      if (cnt_r == 4'h0 && irq_valid_r) cnt_r <= 4'h1;
      else if (cnt_r != 4'h0) cnt_r <= cnt_r + 4'h1;
      // Entry keeps the vector it took
      if (cnt_r == ACK_AT) begin
        irq_ack <= 1'b1;
        taken_vec_r <= irq_vector_r;
      end
      // Return from the handler
      if (cnt_r == 4'h8) irq_exit <= 1'b1;
    end
  end
endmodule // core_model

// ==== verification/core_interrupt_integration_tb.sv ====
`timescale 1ns/1ps
`include "irq_map.vh"
module core_interrupt_integration_tb;
  // Clock, reset and bus master
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  // Sources, pin and core buses
  logic [65:0] src = 66'h0;
  logic nmi_pin_n = 1'b1;
  logic irq_valid_r, irq_ack, irq_exit, nmi_req_r, tick_req_r, code_port_valid_r, code_port_is_data_r, sys_port_valid_r;
  logic [7:0] irq_vector_r, stacked_vector_r, taken_vec;
  logic [3:0] irq_level_r;
  logic ifetch_valid = 1'b0, data_code_bus_valid = 1'b0, sysbus_valid = 1'b0;
  logic [31:0] ifetch_addr = 32'h0, data_code_bus_addr = 32'h0, sysbus_addr = 32'h0, code_port_addr_r, sys_port_addr_r;
  int miscompares = 0, checked = 0, n;
  // Source bit beside the request line it should pend
  typedef struct {int b; int line;} row_t;
  row_t rows [17] = '{'{0, 0}, '{3, 3}, '{4, 16}, '{7, 16}, '{12, 21}, '{13, 22}, '{14, 22}, '{16, 26},
    '{19, 26}, '{20, 31}, '{22, 32}, '{21, 33}, '{23, 34}, '{28, 42}, '{36, 43}, '{51, 44}, '{65, 73}};
  always #50 aclk = ~aclk;
  core_interrupt_integration dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .dma_done(src[3:0]), .dma_err(src[7:4]),
    .misc_irq(src[11:8]), .low_leak_wakeup_unit_irq(src[12]), .software_watchdog_irq(src[13]), .ewm_irq(src[14]), .i2c0_irq(src[15]),
    .spi0_causes(src[19:16]), .uart_stat(src[21:20]), .uart_err(src[23:22]), .analog_irq(src[27:24]),
    .ftm_causes(src[51:28]), .pit_irq(src[55:52]), .misc2_irq(src[59:56]), .port_irq(src[64:60]),
    .adc1_irq(src[65]), .nmi_pin_n(nmi_pin_n), .irq_valid_r(irq_valid_r), .irq_vector_r(irq_vector_r),
    .irq_level_r(irq_level_r), .irq_ack(irq_ack), .irq_exit(irq_exit), .stacked_vector_r(stacked_vector_r),
    .nmi_req_r(nmi_req_r), .tick_req_r(tick_req_r), .ifetch_valid(ifetch_valid), .ifetch_addr(ifetch_addr),
    .data_code_bus_valid(data_code_bus_valid), .data_code_bus_addr(data_code_bus_addr), .sysbus_valid(sysbus_valid), .sysbus_addr(sysbus_addr),
    .code_port_valid_r(code_port_valid_r), .code_port_addr_r(code_port_addr_r),
    .code_port_is_data_r(code_port_is_data_r), .sys_port_valid_r(sys_port_valid_r),
    .sys_port_addr_r(sys_port_addr_r));
  // Core that takes and returns from interrupts
  core_model core_u (.aclk(aclk), .aresetn(aresetn), .irq_valid_r(irq_valid_r), .irq_vector_r(irq_vector_r),
    .irq_ack(irq_ack), .irq_exit(irq_exit), .taken_vec_r(taken_vec));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // Bus read
  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Verdict
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    chk({26'h0, irq_valid_r, nmi_req_r, code_port_valid_r, sys_port_valid_r, bvalid, rvalid}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    $display("test reset done");
    // Each source bit in rows pends its own line, in its own bank and bit
    foreach (rows[i]) begin
      @(posedge aclk);
      src[rows[i].b] <= 1'b1;
      rdr(12'(`OFS_SET_PEND + 4 * (rows[i].line / 32)));
      chk(rd, 32'h1 << (rows[i].line % 32));
      src[rows[i].b] <= 1'b0;
      wr(12'(`OFS_CLR_PEND + 4 * (rows[i].line / 32)), 32'h1 << (rows[i].line % 32));
      rdr(12'(`OFS_SET_PEND + 4 * (rows[i].line / 32)));
      chk(rd, 32'h0);
    end
    $display("test source map done");
    // Fixed tick configuration, also after a write
    wr(`OFS_TICK_CSR, 32'h0);
    rdr(`OFS_TICK_CSR);
    chk(rd & 32'h4, 32'h4);
    rdr(`OFS_TICK_CALIB);
    chk(rd, 32'h8000_0000);
    // Priority fields in upper nibbles of register 14
    wr(12'h338, 32'hffff_ffff);
    rdr(12'h338);
    chk(rd, 32'hf0f0_f0f0);
    // Line without hardware source, pended by software only
    wr(12'h108, 32'h1);
    rdr(12'h108);
    chk(rd, 32'h1);
    wr(12'h188, 32'h1);
    rdr(12'h108);
    chk(rd, 32'h0);
    rdr(12'h600);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    $display("test registers done");
    // Line 58 taken by the core, vector recorded
    wr(`OFS_SET_EN, 32'h0020_0000);
    wr(12'h004, 32'h0400_0000);
    wr(12'h338, 32'h0030_0000);
    @(posedge aclk);
    src[59] <= 1'b1;
    n = 0;
    while (!irq_valid_r && n < 20) begin
      @(posedge aclk);
      n++;
    end
    src[59] <= 1'b0;
    chk({24'h0, irq_vector_r}, 32'h4a);
    chk({28'h0, irq_level_r}, 32'h3);
    n = 0;
    while (stacked_vector_r !== 8'h4a && n < 20) begin
      @(posedge aclk);
      n++;
    end
    rdr(`OFS_STACKED);
    chk(rd, 32'h4a);
    $display("test interrupt done");
    // Pin gives a request only once selected
    @(posedge aclk);
    nmi_pin_n <= 1'b0;
    repeat (3) @(negedge aclk);
    chk({31'h0, nmi_req_r}, 32'h0);
    wr(`OFS_PINMUX, 32'h1);
    repeat (2) @(negedge aclk);
    chk({31'h0, nmi_req_r}, 32'h1);
    @(posedge aclk);
    nmi_pin_n <= 1'b1;
    repeat (2) @(negedge aclk);
    chk({31'h0, nmi_req_r}, 32'h0);
    $display("test nmi done");
    // Tick counts the core clock, wraps and raises its request
    wr(`OFS_TICK_RELOAD, 32'h4);
    wr(`OFS_TICK_CSR, 32'h3);
    repeat (12) @(posedge aclk);
    chk({31'h0, tick_req_r}, 32'h1);
    rdr(`OFS_TICK_CSR);
    chk(rd & 32'h0001_0007, 32'h0001_0007);
    wr(`OFS_TICK_CSR, 32'h0);
    $display("test tick done");
    // Shared code port and separate system port
    @(posedge aclk);
    ifetch_valid <= 1'b1;
    ifetch_addr <= 32'h0000_1230;
    data_code_bus_valid <= 1'b1;
    data_code_bus_addr <= 32'h0000_4560;
    sysbus_valid <= 1'b1;
    sysbus_addr <= 32'h2000_0100;
    @(posedge aclk);
    data_code_bus_valid <= 1'b0;
    @(negedge aclk);
    chk({code_port_valid_r, code_port_is_data_r, code_port_addr_r[29:0]}, 32'hc000_4560);
    chk({sys_port_valid_r, sys_port_addr_r[30:0]}, 32'ha000_0100);
    @(negedge aclk);
    chk({code_port_valid_r, code_port_is_data_r, code_port_addr_r[29:0]}, 32'h8000_1230);
    @(posedge aclk);
    ifetch_valid <= 1'b0;
    sysbus_valid <= 1'b0;
    $display("test buses done");
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (3) @(negedge aclk);
    chk({27'h0, tick_req_r, nmi_req_r, code_port_valid_r, sys_port_valid_r, irq_valid_r}, 32'h0);
    $display("test rereset done");
    stop_test;
  end
endmodule // core_interrupt_integration_tb
